/* verilog/sfs_pkg.sv */
// Shared constants and types for the sampled hysteresis field switch
`default_nettype none

package sfs_pkg;

   // ==========================================================
   // Timing, in nanoseconds and in cycles of the 25 MHz clock
   // ==========================================================
   localparam int CLK_NS          = 40;
   localparam int SAMPLE_NS       = 12500;  // sampling interval, 12.5 us
   localparam int POWER_UP_NS     = 62500;  // power_up_time, 62.5 us
   localparam int UPDATE_DELAY_NS = 12500;  // output_update_delay
   localparam int PHASES          = 4;      // spinning phases per measurement
   localparam int BW_DIVISOR      = 8;      // field_bandwidth = phase_rate / 8
   // Rounded down so one measurement never outlasts the interval
   localparam int PHASE_CYC       = SAMPLE_NS / (CLK_NS * PHASES);
   localparam int SAMPLE_CYC      = PHASE_CYC * PHASES;
   // Least times, rounded up to whole cycles
   localparam int POWER_UP_CYC    = (POWER_UP_NS + CLK_NS - 1) / CLK_NS;
   localparam int UPDATE_DELAY_CYC = (UPDATE_DELAY_NS + CLK_NS - 1) / CLK_NS;

   // ==========================================================
   // Widths
   // ==========================================================
   localparam int FIELD_W     = 16;
   localparam int PHASE_IDX_W = 2;
   localparam int WAIT_W      = 12;
   localparam int CURRENT_W   = 16;
   localparam logic [PHASE_IDX_W-1:0] PHASE_LAST = 2'h3;

   // ==========================================================
   // Supply current levels, in microamps
   // ==========================================================
   localparam logic [CURRENT_W-1:0] HIGH_CURRENT_UA  = 16'h38a4;  // 14.5 mA
   localparam logic [CURRENT_W-1:0] LOW_OPT_A_UA     = 16'h0dac;  // 3.5 mA
   localparam logic [CURRENT_W-1:0] LOW_OPT_B_UA     = 16'h1770;  // 6 mA

   // Start-up sequence, Gray coded along the path
   typedef enum logic [1:0] {
      SFS_POWER_UP = 2'h0,
      SFS_HOLD     = 2'h1,
      SFS_RUN      = 2'h3
   } sfs_state_t;

endpackage

`default_nettype wire

/* verilog/sfs_timebase.sv */
// Phase and sampling timebase divided down from the system clock
`default_nettype none

module sfs_timebase #(
   parameter int PHASE_DIV = sfs_pkg::PHASE_CYC
) (
   // Clock and reset
   input  wire logic                            clock,
   input  wire logic                            rst,
   // Timing outputs
   output logic     [sfs_pkg::PHASE_IDX_W-1:0]  phase,
   output logic                                 phase_end,
   output logic                                 sample_end
);
   import sfs_pkg::*;

   localparam int CW = (PHASE_DIV > 1) ? $clog2(PHASE_DIV) : 1;

   logic [CW-1:0] cyc;

   // ==========================================================
   // Phase boundaries
   // ==========================================================
   // A sample ends with the last phase of the spin
   assign phase_end  = (cyc == CW'(PHASE_DIV - 1));
   assign sample_end = phase_end && (phase == PHASE_LAST);

   // Cycle counter and phase index, the index wraps by width
   always_ff @(posedge clock) begin
      if (rst) begin
         cyc   <= '0;
         phase <= '0;
      end else if (phase_end) begin
         cyc   <= '0;
         phase <= phase + 1'b1;
      end else begin
         cyc   <= cyc + 1'b1;
      end
   end

endmodule

`default_nettype wire

/* verilog/sfs_spin_accum.sv */
// Accumulator averaging the four spinning-phase field values
`default_nettype none

module sfs_spin_accum #(
   parameter int W = sfs_pkg::FIELD_W
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // Phase values and timing
   input  wire logic signed [W-1:0]  phase_value,
   input  wire logic                 phase_end,
   input  wire logic                 sample_end,
   // Averaged result
   output logic     signed [W-1:0]   average,
   output logic                      average_valid
);
   import sfs_pkg::*;

   localparam int SW = W + PHASE_IDX_W;

   logic signed [SW-1:0] sum;
   wire  signed [SW-1:0] total;

   // ==========================================================
   // Integration
   // ==========================================================
   // Extra bits so four full-scale phases cannot overflow
   assign total = sum + SW'(phase_value);

   // Each phase value is taken in its last cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         sum           <= '0;
         average       <= '0;
         average_valid <= 1'b0;
      end else begin
         average_valid <= 1'b0;
         if (phase_end && sample_end) begin
            average       <= W'(total >>> PHASE_IDX_W);
            sum           <= '0;
            average_valid <= 1'b1;
         end else if (phase_end) begin
            sum <= total;
         end
      end
   end

endmodule

`default_nettype wire

/* verilog/sfs_field_switch.sv */
// Decision core of the two-wire sampled hysteresis field switch
`default_nettype none

module sfs_field_switch #(
   parameter int   PHASE_DIV         = sfs_pkg::PHASE_CYC,
   parameter int   POWER_UP_WAIT     = sfs_pkg::POWER_UP_CYC,
   parameter int   UPDATE_WAIT       = sfs_pkg::UPDATE_DELAY_CYC,
   parameter int   OPERATE_THRESHOLD = 400,
   parameter int   RELEASE_THRESHOLD = 200,
   parameter bit   LOW_OPTION_B      = 1'b0
) (
   // Clock and reset
   input  wire logic                                  clock,
   input  wire logic                                  rst,
   // Demodulated field value of the current spinning phase
   input  wire logic signed [sfs_pkg::FIELD_W-1:0]    field_phase,
   // Spinning control toward the sensing element
   output logic            [sfs_pkg::PHASE_IDX_W-1:0] spin_phase,
   output logic                                       sample_strobe,
   // Supply current selection
   output logic                                       level_defined,
   output logic                                       supply_low,
   output logic            [sfs_pkg::CURRENT_W-1:0]   supply_current_ua
);
   import sfs_pkg::*;

   // ==========================================================
   // Fixed thresholds and level
   // ==========================================================
   // Only one mode: thresholds and option are build-time constants
   localparam logic signed [FIELD_W-1:0] OPERATE_T = FIELD_W'(OPERATE_THRESHOLD);
   localparam logic signed [FIELD_W-1:0] RELEASE_T = FIELD_W'(RELEASE_THRESHOLD);
   localparam logic [CURRENT_W-1:0] LOW_UA = LOW_OPTION_B ? LOW_OPT_B_UA : LOW_OPT_A_UA;
   localparam logic [WAIT_W-1:0] PU_LAST  = WAIT_W'(POWER_UP_WAIT - 1);
   localparam logic [WAIT_W-1:0] UPD_LAST = WAIT_W'(UPDATE_WAIT - 1);
   localparam logic signed [FIELD_W-1:0] ZERO_FIELD = '0;

   sfs_state_t                   state;
   sfs_state_t                   next_state;
   logic        [WAIT_W-1:0]     wait_cnt;
   logic                         next_low;
   logic                         phase_end;
   logic                         sample_end;
   logic signed [FIELD_W-1:0]    average;
   logic                         average_valid;
   wire  signed [FIELD_W-1:0]    positive_avg;
   wire  signed [FIELD_W-1:0]    active_threshold;
   wire                          above_operate;
   wire                          below_release;
   wire                          wait_done;
   wire                          deciding;

   // ==========================================================
   // Timebase and spinning accumulator
   // ==========================================================
   // One counter drives phases and the sampling interval
   sfs_timebase #(
      .PHASE_DIV (PHASE_DIV)
   ) u_timebase (
      .clock      (clock),
      .rst        (rst),
      .phase      (spin_phase),
      .phase_end  (phase_end),
      .sample_end (sample_end)
   );

   // Average of the four phases, cleared by reset
   sfs_spin_accum #(
      .W (FIELD_W)
   ) u_accum (
      .clock         (clock),
      .rst           (rst),
      .phase_value   (field_phase),
      .phase_end     (phase_end),
      .sample_end    (sample_end),
      .average       (average),
      .average_valid (average_valid)
   );

   assign sample_strobe = sample_end;

   // ==========================================================
   // Comparator with hysteresis
   // ==========================================================
   // Negative fields are floored to zero so they never operate
   assign positive_avg = (average < ZERO_FIELD) ? ZERO_FIELD : average;
   // Threshold follows the current output state
   assign active_threshold = supply_low ? RELEASE_T : OPERATE_T;
   assign above_operate = !supply_low && (positive_avg > active_threshold);
   assign below_release = supply_low && (positive_avg < active_threshold);

   // Decisions only at the end of a full spin, while running
   assign deciding = (state == SFS_RUN) && average_valid;

   // Next output level
   always_comb begin
      next_low = supply_low;
      if (state != SFS_RUN) begin
         next_low = 1'b0;
      end else if (deciding && above_operate) begin
         next_low = 1'b1;
      end else if (deciding && below_release) begin
         next_low = 1'b0;
      end
   end

   // ==========================================================
   // Start-up sequence
   // ==========================================================
   assign wait_done = (state == SFS_POWER_UP) ? (wait_cnt == PU_LAST)
                                              : (wait_cnt == UPD_LAST);

   // Power-up wait, then update delay at high, then normal run
   always_comb begin
      next_state = state;
      unique case (state)
         SFS_POWER_UP: begin
            if (wait_done) begin
               next_state = SFS_HOLD;
            end
         end
         SFS_HOLD: begin
            if (wait_done) begin
               next_state = SFS_RUN;
            end
         end
         SFS_RUN: begin
            next_state = SFS_RUN;
         end
         default: begin
            next_state = SFS_POWER_UP;
         end
      endcase
   end

   // State and wait counter
   always_ff @(posedge clock) begin
      if (rst) begin
         state    <= SFS_POWER_UP;
         wait_cnt <= '0;
      end else begin
         state    <= next_state;
         wait_cnt <= (next_state != state || state == SFS_RUN) ? '0 : wait_cnt + 1'b1;
      end
   end

   // ==========================================================
   // Output level registers
   // ==========================================================
   // Reset presets the high level; it is flagged undefined until power-up ends
   always_ff @(posedge clock) begin
      if (rst) begin
         supply_low        <= 1'b0;
         level_defined     <= 1'b0;
         supply_current_ua <= HIGH_CURRENT_UA;
      end else begin
         supply_low        <= next_low;
         level_defined     <= (next_state != SFS_POWER_UP);
         supply_current_ua <= next_low ? LOW_UA : HIGH_CURRENT_UA;
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // Helper: cycles since the last sample strobe
   logic [WAIT_W-1:0] gap_cnt;
   logic              gap_seen;
   always_ff @(posedge clock) begin
      if (rst) begin
         gap_cnt  <= '0;
         gap_seen <= 1'b0;
      end else if (sample_end) begin
         gap_cnt  <= '0;
         gap_seen <= 1'b1;
      end else begin
         gap_cnt  <= gap_cnt + 1'b1;
      end
   end

   sequence s_operate;
      deciding && !supply_low && (average > OPERATE_T);
   endsequence

   sequence s_release;
      deciding && supply_low && (average < RELEASE_T);
   endsequence

   sequence s_held_low;
      (state == SFS_RUN) && supply_low && !(average_valid && average < RELEASE_T);
   endsequence

   // Helper: cycles since the last phase boundary
   logic [WAIT_W-1:0] phase_cnt;
   always_ff @(posedge clock) begin
      if (rst || phase_end) begin
         phase_cnt <= '0;
      end else begin
         phase_cnt <= phase_cnt + 1'b1;
      end
   end

   // Last cycle of the update delay, and the first run cycle after it
   sequence s_hold_end;
      (state == SFS_HOLD) && wait_done;
   endsequence

   sequence s_run_entry;
      (state == SFS_RUN) && !supply_low && level_defined;
   endsequence

   sequence s_run_entered;
      (state == SFS_RUN) && ($past(state) == SFS_HOLD);
   endsequence

   a_reset_high_level: assert property (
      $fell(rst) |-> !supply_low && (state == SFS_POWER_UP) && !level_defined)
      else $error("level not high after reset");

   a_operate_low: assert property (s_operate |=> supply_low)
      else $error("no switch to low above operate");

   a_release_hold: assert property (s_held_low |=> supply_low)
      else $error("low level left before release");

   a_release_high: assert property (s_release |=> !supply_low)
      else $error("no switch to high below release");

   a_current_code: assert property (
      supply_current_ua == (supply_low ? LOW_UA : HIGH_CURRENT_UA))
      else $error("current code does not match level");

   a_negative_field: assert property (
      deciding && !supply_low && average < ZERO_FIELD |=> !supply_low)
      else $error("negative field selected low");

   a_hold_high: assert property (
      (state == SFS_HOLD) |=> !supply_low && level_defined)
      else $error("level not high in update delay");

   a_powerup_len: assert property (
      (state == SFS_HOLD) && ($past(state) == SFS_POWER_UP) |-> $past(wait_cnt) == PU_LAST)
      else $error("power-up wait has wrong length");

   a_sample_gap: assert property (
      sample_end && gap_seen |-> gap_cnt == WAIT_W'(PHASE_DIV * PHASES - 1))
      else $error("sampling interval wrong");

   a_change_on_sample: assert property (
      (state == SFS_RUN) && $changed(supply_low) |-> $past(average_valid))
      else $error("level changed between samples");

   a_phase_order: assert property (
      phase_end |=> spin_phase == PHASE_IDX_W'($past(spin_phase) + 1'b1))
      else $error("spinning phase out of order");

   a_spin_complete: assert property (
      sample_end |=> average_valid ##1 !average_valid)
      else $error("average not one pulse after spin");

   a_phase_length: assert property (
      phase_end |-> phase_cnt == WAIT_W'(PHASE_DIV - 1))
      else $error("spinning phase has wrong length");

   a_level_defined: assert property (
      level_defined == (state != SFS_POWER_UP))
      else $error("level flagged defined during power-up");

   a_high_before_run: assert property (
      (state != SFS_RUN) |-> !supply_low)
      else $error("low level before normal run");

   a_hold_length: assert property (
      s_run_entered |-> $past(wait_cnt) == UPD_LAST)
      else $error("update delay has wrong length");

   a_run_entry: assert property (
      s_hold_end |=> s_run_entry)
      else $error("run not entered high after update delay");

   a_single_mode: assert property (
      (state == SFS_RUN) |=> (state == SFS_RUN))
      else $error("normal run left without reset");

   a_gap_bound: assert property (
      gap_seen |-> gap_cnt <= WAIT_W'(PHASE_DIV * PHASES - 1))
      else $error("sampling interval overrun");

endmodule

`default_nettype wire

/* dv/sfs_field_source.sv */
// Behavioural spinning sensing element feeding the field switch
`default_nettype none

module sfs_field_source (
   // Spinning control from the switch
   input  wire logic        [sfs_pkg::PHASE_IDX_W-1:0] spin_phase,
   // Applied field and element offset, set by the bench
   input  wire logic signed [sfs_pkg::FIELD_W-1:0]     field,
   input  wire logic signed [sfs_pkg::FIELD_W-1:0]     offset,
   // Demodulated value of the current phase
   output logic      signed [sfs_pkg::FIELD_W-1:0]     field_phase
);
   timeunit 1ns;
   timeprecision 1ps;
   import sfs_pkg::*;

   // Offset flips sign each phase, so each pair of phases cancels it
   assign field_phase = spin_phase[0] ? field - offset : field + offset;
endmodule

`default_nettype wire

/* dv/sfs_field_switch_tb.sv */
// Self-checking testbench for the sampled hysteresis field switch
`default_nettype none

module sfs_field_switch_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sfs_pkg::*;

   // ========================================
   // Shortened timing and thresholds
   // ========================================
   localparam int PDIV   = 2;
   localparam int PUW    = 8;
   localparam int UDW    = 8;
   localparam int OP     = 400;
   localparam int REL    = 200;
   localparam int SAMPLE = 4 * PDIV;

   logic                          clock = 1'b0;
   logic                          rst = 1'b1;
   logic signed [FIELD_W-1:0]     field = 16'h0000;
   logic signed [FIELD_W-1:0]     offset = 16'h0000;
   logic signed [FIELD_W-1:0]     field_phase;
   logic        [PHASE_IDX_W-1:0] spin_phase;
   logic                          sample_strobe;
   logic                          level_defined;
   logic                          supply_low;
   logic        [CURRENT_W-1:0]   current;
   logic        [CURRENT_W-1:0]   current_b;
   int                            errors = 0;
   int                            checks = 0;
   int                            since = 0;
   logic                          seen_strobe = 1'b0;
   logic                          prev_low = 1'b0;
   logic        [PHASE_IDX_W-1:0] prev_phase = 2'h0;

   // ========================================
   // Design, option B twin and field model
   // ========================================
   sfs_field_switch #(.PHASE_DIV(PDIV), .POWER_UP_WAIT(PUW), .UPDATE_WAIT(UDW),
      .OPERATE_THRESHOLD(OP), .RELEASE_THRESHOLD(REL), .LOW_OPTION_B(1'b0)) u_dut (
      .clock(clock), .rst(rst), .field_phase(field_phase), .spin_phase(spin_phase),
      .sample_strobe(sample_strobe), .level_defined(level_defined), .supply_low(supply_low),
      .supply_current_ua(current));
   // Twin shows the other low-current option, and the high current in reset
   sfs_field_switch #(.PHASE_DIV(PDIV), .POWER_UP_WAIT(PUW), .UPDATE_WAIT(UDW),
      .OPERATE_THRESHOLD(OP), .RELEASE_THRESHOLD(REL), .LOW_OPTION_B(1'b1)) u_dut_b (
      .clock(clock), .rst(rst), .field_phase(field_phase), .spin_phase(),
      .sample_strobe(), .level_defined(), .supply_low(), .supply_current_ua(current_b));
   sfs_field_source u_source (
      .spin_phase(spin_phase), .field(field), .offset(offset), .field_phase(field_phase));

   // Clock, 40 ns period
   always #20 clock = ~clock;

   // ========================================
   // Shared tasks
   // ========================================
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      checks++;
      if (got !== want) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, want);
      end
   endtask

   task automatic conclude;
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Inputs always move 1 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clock);
         #1;
      end
   endtask

   task automatic set_field(input int f, input int o);
      field = 16'(f);
      offset = 16'(o);
   endtask

   // Bounded wait for a level change; a miss ends the run
   task automatic wait_low(input logic v);
      int i;
      for (i = 0; i < 3 * SAMPLE + 4 && supply_low !== v; i++) cyc(1);
      if (supply_low !== v) begin
         check(32'(supply_low), 32'(v));
         conclude();
      end
   endtask

   // Level must not move for n cycles
   task automatic hold(input int n, input logic v);
      repeat (n) begin
         cyc(1);
         check(32'(supply_low), 32'(v));
      end
   endtask

   // ========================================
   // Timing monitor
   // ========================================
   // Strobe spacing, phase order and decision latency, judged every edge out of reset
   always @(posedge clock) begin
      if (rst) begin
         seen_strobe <= 1'b0;
         since <= 0;
         prev_low <= 1'b0;
         prev_phase <= 2'h0;
      end else begin
         if (sample_strobe === 1'b1) begin
            if (seen_strobe) check(32'(since), 32'(SAMPLE - 1));
            check(32'(spin_phase), 32'h3);
            seen_strobe <= 1'b1;
            since <= 0;
         end else begin
            since <= since + 1;
         end
         // Wrap the expected index at two bits, else 3 would be followed by 4
         if (spin_phase !== prev_phase) check(32'(spin_phase), 32'(PHASE_IDX_W'(prev_phase + 2'h1)));
         // Level moves two cycles after the strobe that closed the spin
         if (supply_low !== prev_low) check(32'(since), 32'h1);
         prev_low <= supply_low;
         prev_phase <= spin_phase;
      end
   end

   // ========================================
   // Scenarios
   // ========================================
   // Strong field present from power-up: level still starts high
   task automatic t_startup;
      set_field(OP + 600, 0);
      rst = 1'b1;
      cyc(4);
      rst = 1'b0;
      check(32'(supply_low), 32'h0);
      check(32'(current), 32'h38a4);
      check(32'(level_defined), 32'h0);
      check(32'(spin_phase), 32'h0);
      hold(PUW + UDW, 1'b0);
      check(32'(level_defined), 32'h1);
      wait_low(1'b1);
      check(32'(current), 32'h0dac);
      check(32'(current_b), 32'h1770);
   endtask

   // Band between thresholds and both exact threshold values
   task automatic t_hyst;
      set_field(REL + 100, 0);
      hold(3 * SAMPLE, 1'b1);
      set_field(REL, 0);
      hold(3 * SAMPLE, 1'b1);
      set_field(REL - 1, 0);
      wait_low(1'b0);
      check(32'(current), 32'h38a4);
      set_field(OP, 0);
      hold(3 * SAMPLE, 1'b0);
      set_field(OP + 1, 0);
      wait_low(1'b1);
   endtask

   // Negative field and large per-phase offsets
   task automatic t_polarity;
      set_field(-2000, 0);
      wait_low(1'b0);
      hold(4 * SAMPLE, 1'b0);
      set_field(0, 2 * OP);
      hold(4 * SAMPLE, 1'b0);
      set_field(OP + 1, 2 * OP);
      wait_low(1'b1);
   endtask

   // Reset in mid-run while low: back to the start-up sequence
   task automatic t_reset;
      rst = 1'b1;
      cyc(1);
      check(32'(supply_low), 32'h0);
      check(32'(level_defined), 32'h0);
      check(32'(current_b), 32'h38a4);
      cyc(3);
      rst = 1'b0;
      hold(PUW + UDW, 1'b0);
      wait_low(1'b1);
   endtask

   initial begin
      t_startup();
      t_hyst();
      t_polarity();
      t_reset();
      conclude();
   end
endmodule

`default_nettype wire
